// ### hdl/bmh_regs.svh
// Timing, reset values and widths for the bus mastership handover block
`ifndef BMH_REGS_SVH
`define BMH_REGS_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define BMH_CLK_PERIOD_NS 50

// ----------------------------------------------------------------------
// Handover times in tenths of a clock period, BMH_ACK_TO_REQ_MIN_NS in ns, as printed
// ----------------------------------------------------------------------
`define BMH_GRANT_MIN_X10 15
`define BMH_GRANT_MAX_X10 35
`define BMH_CODE_RESUME_X10 10
`define BMH_STROBE_RESUME_X10 15
`define BMH_ACK_TO_REQ_MAX_X10 15
`define BMH_ACK_TO_REQ_MIN_NS 20

// ----------------------------------------------------------------------
// Derived cycle counts: least times round up, longest round down
// ----------------------------------------------------------------------
`define BMH_GRANT_MIN_CYC ((`BMH_GRANT_MIN_X10 + 9) / 10)
`define BMH_GRANT_MAX_CYC (`BMH_GRANT_MAX_X10 / 10)
`define BMH_CODE_RESUME_CYC ((`BMH_CODE_RESUME_X10 + 9) / 10)
`define BMH_STROBE_RESUME_CYC ((`BMH_STROBE_RESUME_X10 + 9) / 10)

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define BMH_ASYNC_W 8
`define BMH_CNT_W 2
`define BMH_OE_RST 1'h1
`define BMH_GRANT_RST 1'h0

`endif

// ### hdl/bmh_pkg.sv
// Types shared by the bus mastership handover block
package bmh_pkg;

    // ------------------------------------------------------------------
    // Handover states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle     = 3'h0,
        st_granted  = 3'h1,
        st_released = 3'h2,
        st_resume   = 3'h3
    } bmh_state_t;

    // ------------------------------------------------------------------
    // Asynchronous inputs, active high
    // ------------------------------------------------------------------
    typedef struct packed {
        logic bus_request_in;
        logic grant_acknowledge_in;
        logic bus_error_in;
        logic transfer_acknowledge_in;
        logic peripheral_address_valid_in;
        logic [2:0] interrupt_level_in;
    } bmh_async_t;

    // ------------------------------------------------------------------
    // Bus control outputs of the processor
    // ------------------------------------------------------------------
    typedef struct packed {
        logic address_strobe_out;
        logic data_strobe_upper;
        logic data_strobe_lower;
        logic read_write;
        logic [2:0] cycle_type_code;
        logic valid_memory_access_out;
    } bmh_ctl_t;

endpackage : bmh_pkg

// ### hdl/bmh_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module bmh_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_reg <= '0;
            o_q <= '0;
        end else if (i_ce) begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule : bmh_sync

// ### hdl/bmh_arbiter.sv
// Bus mastership handover logic of the processor
//
// What this block does
// - Grant is raised 1.5 to 3.5 clocks after a bus request is seen.
// - A request withdrawn while granted drops the grant within 1.5 to 3.5 clocks.
// - A grant acknowledge drops the grant within 1.5 to 3.5 clocks.
// - A request still held when the acknowledge ends makes the grant come back.
// - Strobes and read/write are driven again no sooner than 1.5 clocks after acknowledge ends.
// - Cycle type code and valid access are driven again no sooner than 1 clock after acknowledge ends.
// - After an unacknowledged withdrawal, strobes and read/write wait at least 1.5 clocks.
// - After an unacknowledged withdrawal, cycle type code and valid access wait at least 1 clock.
// - A request dropped before any acknowledge cancels the grant and the bus is taken back.
// - All asynchronous inputs are recognised through a two-stage synchroniser.
// - After granting, control, address and data float once no core cycle is active (i_core_cycle_active low).
`timescale 1ns/1ps
`include "bmh_regs.svh"
module bmh_arbiter (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire bmh_pkg::bmh_async_t i_async,
    input wire bmh_pkg::bmh_ctl_t i_core_ctl,
    input wire logic i_core_cycle_active,
    output bmh_pkg::bmh_async_t o_sync,
    output logic o_bus_grant_out,
    output logic o_core_hold,
    output logic o_strobe_oe,
    output logic o_code_oe,
    output logic o_addr_data_oe,
    output bmh_pkg::bmh_ctl_t o_bus_ctl
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    bmh_sync #(
        .WIDTH(`BMH_ASYNC_W)
    ) bmh_sync_inst (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_d(i_async),
        .o_q(o_sync)
    );

    logic req_s;
    logic ack_s;
    assign req_s = o_sync.bus_request_in;
    assign ack_s = o_sync.grant_acknowledge_in;

    // ------------------------------------------------------------------
    // Handover state machine
    // ------------------------------------------------------------------
    bmh_pkg::bmh_state_t state_reg;
    bmh_pkg::bmh_state_t state_next;
    logic [`BMH_CNT_W-1:0] cnt_reg;
    logic [`BMH_CNT_W-1:0] cnt_next;
    logic code_due;
    logic strobe_due;

    assign code_due = cnt_next >= (`BMH_CNT_W)'(`BMH_CODE_RESUME_CYC);
    assign strobe_due = cnt_next >= (`BMH_CNT_W)'(`BMH_STROBE_RESUME_CYC);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            bmh_pkg::st_idle: begin
                cnt_next = '0;
                // Grant one cycle after the synchronised request
                if (req_s && !ack_s) begin
                    state_next = bmh_pkg::st_granted;
                end
            end
            bmh_pkg::st_granted: begin
                cnt_next = '0;
                if (ack_s) begin
                    state_next = bmh_pkg::st_released;
                end else if (!req_s) begin
                    state_next = bmh_pkg::st_resume;
                end
            end
            bmh_pkg::st_released: begin
                cnt_next = '0;
                if (!ack_s && req_s) begin
                    // Requester held its request too long
                    state_next = bmh_pkg::st_granted;
                end else if (!ack_s) begin
                    state_next = bmh_pkg::st_resume;
                end
            end
            bmh_pkg::st_resume: begin
                cnt_next = cnt_reg + (`BMH_CNT_W)'(1);
                if (strobe_due) begin
                    state_next = bmh_pkg::st_idle;
                end
            end
            default: begin
                cnt_next = '0;
                state_next = bmh_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= bmh_pkg::st_idle;
            cnt_reg <= '0;
        end else if (i_ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Grant output
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_grant_out <= `BMH_GRANT_RST;
        end else if (i_ce) begin
            o_bus_grant_out <= (state_next == bmh_pkg::st_granted);
        end
    end

    // ------------------------------------------------------------------
    // Core hold: no new cycle may start once a grant is pending
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_core_hold <= 1'h0;
        end else if (i_ce) begin
            o_core_hold <= (state_next != bmh_pkg::st_idle);
        end
    end

    // ------------------------------------------------------------------
    // Output enables
    // ------------------------------------------------------------------
    // Float only between cycles; a grant during a cycle waits for its end
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_addr_data_oe <= `BMH_OE_RST;
            o_strobe_oe <= `BMH_OE_RST;
            o_code_oe <= `BMH_OE_RST;
        end else if (i_ce) begin
            if (state_reg == bmh_pkg::st_granted && !i_core_cycle_active) begin
                o_addr_data_oe <= 1'h0;
                o_strobe_oe <= 1'h0;
                o_code_oe <= 1'h0;
            end else if (state_reg == bmh_pkg::st_resume) begin
                if (code_due) begin
                    o_code_oe <= 1'h1;
                end
                if (strobe_due) begin
                    o_strobe_oe <= 1'h1;
                    o_addr_data_oe <= 1'h1;
                end
            end
        end
    end

    // Strobe values follow the core, one register stage
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_ctl <= '0;
        end else if (i_ce) begin
            o_bus_ctl <= i_core_ctl;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_grant_on_req: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && state_reg == bmh_pkg::st_idle && req_s && !ack_s) |=> o_bus_grant_out
    ) else $error("Grant not raised after request");

    chk_grant_raw_lat: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && state_reg == bmh_pkg::st_idle && !ack_s && !$past(o_sync.bus_request_in)
            && i_async.bus_request_in) ##1 (i_ce && i_async.bus_request_in && !i_async.grant_acknowledge_in)
            ##1 (i_ce && i_async.bus_request_in) |-> ##[0:1] o_bus_grant_out
    ) else $error("Grant latency out of range");

    chk_grant_drop_req: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && state_reg == bmh_pkg::st_granted && !req_s && !ack_s) |=> !o_bus_grant_out
            && state_reg == bmh_pkg::st_resume
    ) else $error("Grant held after request withdrawn");

    chk_grant_drop_ack: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && state_reg == bmh_pkg::st_granted && ack_s) |=> !o_bus_grant_out
    ) else $error("Grant held after acknowledge");

    chk_regrant_late: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && state_reg == bmh_pkg::st_released && !ack_s && req_s) |=> o_bus_grant_out
    ) else $error("No regrant on held request");

    chk_strobe_resume: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_strobe_oe) |-> $past(o_code_oe) && $past(state_reg) == bmh_pkg::st_resume
            && !$past(ack_s, 2)
    ) else $error("Strobes driven too early");

    chk_code_resume: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_code_oe) |-> $past(state_reg) == bmh_pkg::st_resume && !$past(ack_s)
    ) else $error("Code outputs driven too early");

    chk_cancel_take: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && state_reg == bmh_pkg::st_granted && !req_s && !ack_s) ##1 i_ce[*2] |=> o_addr_data_oe
    ) else $error("Bus not taken back after cancel");

    chk_sync_delay: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && $past(i_ce) && $past(i_ce, 2)) |-> o_sync == $past(i_async, 2)
    ) else $error("Asynchronous input not synchronised");

    chk_float_boundary: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        $fell(o_addr_data_oe) |-> $past(state_reg) == bmh_pkg::st_granted
            && !$past(i_core_cycle_active) && !o_strobe_oe
    ) else $error("Bus floated mid cycle");

    chk_hold_floating: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        !o_addr_data_oe |-> o_core_hold
    ) else $error("Core free while bus floated");

endmodule : bmh_arbiter

// ### tb/bmh_partner.sv
// Partner model: outside arbiter and alternate bus master
`timescale 1ns/1ps
module bmh_partner (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_grant,
    input wire logic i_start,
    input wire logic i_cancel,
    input wire logic i_use_ack,
    input wire logic i_late,
    output logic o_req,
    output logic o_ack
);
    logic [1:0] st_reg;
    logic [2:0] cnt_reg;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_req <= 1'b0;
            o_ack <= 1'b0;
            st_reg <= 2'h0;
            cnt_reg <= 3'h0;
        end else begin
            case (st_reg)
                2'h0: begin
                    if (i_start) begin
                        o_req <= 1'b1;
                        st_reg <= 2'h1;
                    end else if (i_cancel) begin
                        o_req <= 1'b0;
                    end
                end
                2'h1: begin
                    if (i_cancel) begin
                        o_req <= 1'b0;
                        st_reg <= 2'h0;
                    end else if (i_grant && i_use_ack) begin
                        o_ack <= 1'b1;
                        cnt_reg <= 3'h0;
                        st_reg <= 2'h2;
                    end
                end
                default: begin
                    cnt_reg <= cnt_reg + 3'h1;
                    // One clock after acknowledge: past 20 ns, inside 1.5 clocks
                    if (!i_late) begin
                        o_req <= 1'b0;
                    end
                    if (cnt_reg == 3'h4) begin
                        o_ack <= 1'b0;
                        st_reg <= 2'h0;
                    end
                end
            endcase
        end
    end
endmodule : bmh_partner

// ### tb/bus_mastership_handover_bench.sv
// Self-checking bench for the bus mastership handover block
`timescale 1ns/1ps
module bus_mastership_handover_bench;
    logic i_mclk, i_rst_b, i_ce, core_active, start, cancel, use_ack, late, req, ack;
    logic grant, hold, strobe_oe, code_oe, addr_oe;
    logic [5:0] stat;
    bmh_pkg::bmh_async_t async_in, sync_out;
    bmh_pkg::bmh_ctl_t core_ctl, bus_ctl;
    time tm[5];
    int n_fail = 0;
    int checks = 0;

    assign async_in = {req, ack, stat};
    always @(posedge req) tm[0] = $time;
    always @(negedge req) tm[1] = $time;
    always @(posedge ack) tm[2] = $time;
    always @(negedge ack) tm[3] = $time;

    bmh_arbiter bmh_arbiter_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_async(async_in),
        .i_core_ctl(core_ctl), .i_core_cycle_active(core_active), .o_sync(sync_out),
        .o_bus_grant_out(grant), .o_core_hold(hold), .o_strobe_oe(strobe_oe), .o_code_oe(code_oe),
        .o_addr_data_oe(addr_oe), .o_bus_ctl(bus_ctl));
    bmh_partner bmh_partner_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_grant(grant), .i_start(start),
        .i_cancel(cancel), .i_use_ack(use_ack), .i_late(late), .o_req(req), .o_ack(ack));

    initial i_mclk = 1'b0;
    always #25 i_mclk = ~i_mclk;

    task automatic report_and_stop();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    function automatic logic pick(input int k);
        case (k)
            0: return grant;
            1: return strobe_oe;
            2: return code_oe;
            default: return addr_oe;
        endcase
    endfunction : pick

    // Waits for a level, then judges its distance from a recorded pin change
    task automatic wait_sig(input int k, input logic lvl, input int ti, input int lo, input int hi);
        int n;
        time d;
        n = 0;
        while (pick(k) !== lvl && n < 40) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        d = $time - 1 - tm[ti];
        check({6'h0, pick(k), (d >= lo && d <= hi)}, {6'h0, lvl, 1'b1}, "handover delay");
    endtask : wait_sig

    task automatic pulse(input logic is_start);
        @(posedge i_mclk);
        if (is_start) begin
            start <= 1'b1;
        end else begin
            cancel <= 1'b1;
        end
        @(posedge i_mclk);
        start <= 1'b0;
        cancel <= 1'b0;
        #1;
    endtask : pulse

    task automatic sc_handover();
        use_ack <= 1'b1;
        late <= 1'b0;
        pulse(1'b1);
        wait_sig(0, 1'b1, 0, 75, 175);
        wait_sig(3, 1'b0, 0, 0, 300);
        wait_sig(0, 1'b0, 2, 75, 175);
        check({7'h0, (tm[1] - tm[2] >= 20 && tm[1] - tm[2] <= 75)}, 8'h01, "request drop");
        wait_sig(2, 1'b1, 3, 50, 400);
        wait_sig(1, 1'b1, 3, 75, 400);
        @(posedge i_mclk);
        #1;
        check({7'h0, hold}, 8'h00, "hold after resume");
    endtask : sc_handover

    task automatic sc_cancel();
        use_ack <= 1'b0;
        pulse(1'b1);
        wait_sig(0, 1'b1, 0, 75, 175);
        pulse(1'b0);
        wait_sig(0, 1'b0, 1, 75, 175);
        wait_sig(2, 1'b1, 1, 50, 400);
        wait_sig(1, 1'b1, 1, 75, 400);
        wait_sig(3, 1'b1, 1, 75, 400);
    endtask : sc_cancel

    task automatic sc_regrant();
        use_ack <= 1'b1;
        late <= 1'b1;
        pulse(1'b1);
        wait_sig(0, 1'b1, 0, 75, 175);
        wait_sig(0, 1'b0, 2, 75, 175);
        wait_sig(0, 1'b1, 3, 75, 175);
        late <= 1'b0;
        pulse(1'b0);
        wait_sig(0, 1'b0, 1, 75, 175);
        wait_sig(1, 1'b1, 1, 75, 400);
    endtask : sc_regrant

    task automatic sc_active_cycle();
        use_ack <= 1'b0;
        @(posedge i_mclk);
        core_active <= 1'b1;
        pulse(1'b1);
        wait_sig(0, 1'b1, 0, 75, 175);
        repeat (3) @(posedge i_mclk);
        #1;
        check({6'h0, addr_oe, hold}, 8'h03, "bus kept during cycle");
        @(posedge i_mclk);
        core_active <= 1'b0;
        tm[4] = $time;
        #1;
        wait_sig(3, 1'b0, 4, 0, 100);
        pulse(1'b0);
        wait_sig(1, 1'b1, 1, 75, 400);
    endtask : sc_active_cycle

    task automatic sc_sync();
        @(posedge i_mclk);
        stat <= 6'h3d;
        core_ctl <= 8'ha5;
        @(posedge i_mclk);
        #1;
        check(bus_ctl, 8'ha5, "core control delay");
        check({2'h0, sync_out[5:0]}, 8'h00, "sync too early");
        @(posedge i_mclk);
        #1;
        check({2'h0, sync_out[5:0]}, 8'h3d, "sync value");
    endtask : sc_sync

    // Enable low must freeze the synchroniser and the grant path
    task automatic sc_freeze();
        use_ack <= 1'b0;
        @(posedge i_mclk);
        i_ce <= 1'b0;
        pulse(1'b1);
        repeat (4) @(posedge i_mclk);
        #1;
        check({6'h0, grant, sync_out.bus_request_in}, 8'h00, "frozen by enable");
        @(posedge i_mclk);
        i_ce <= 1'b1;
        tm[4] = $time;
        #1;
        wait_sig(0, 1'b1, 4, 75, 175);
        pulse(1'b0);
        wait_sig(0, 1'b0, 1, 75, 175);
        wait_sig(3, 1'b1, 1, 75, 400);
    endtask : sc_freeze

    initial begin
        repeat (4000) @(posedge i_mclk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        i_rst_b = 1'b0;
        i_ce = 1'b1;
        stat = 6'h0;
        core_ctl = 8'h0;
        core_active = 1'b0;
        start = 1'b0;
        cancel = 1'b0;
        use_ack = 1'b0;
        late = 1'b0;
        repeat (16) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        #1;
        check({3'h0, grant, hold, strobe_oe, code_oe, addr_oe}, 8'h07, "reset outputs");
        sc_sync();
        sc_handover();
        sc_cancel();
        sc_regrant();
        sc_active_cycle();
        sc_freeze();
        report_and_stop();
    end
endmodule : bus_mastership_handover_bench
